/* ovd_asserts.sv */
`timescale 1ns/10ps
// ****
// Port checks.
// ****
module ovd_asserts (
	input wire logic        clock_in,
	input wire logic        srst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic        soft_start_in,
	input wire logic        oring_switch_enable_in,
	input wire logic        pready_out,
	input wire logic [31:0] prdata_out,
	input wire logic        pslverr_out,
	input wire logic        local_ov_flag_out,
	input wire logic        load_ov_flag_out,
	input wire logic        regulate_remote_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	logic [1:0]  prev_q;
	logic [10:0] gap_q;
	logic        seen_q;
	logic        rst_q;
	// A flag moved, and the access targets a mapped word.
	wire         move = {load_ov_flag_out, local_ov_flag_out} != prev_q;
	wire         hit  = paddr_in == 12'h0C8 || paddr_in == 12'h0CC || (paddr_in[11:4] == 8'h10 && paddr_in[1:0] == 2'h0);
	// Track the cycle distance between flag movements, modulo one period.
	always_ff @(posedge clock_in) begin
		rst_q  <= srst_in;
		prev_q <= srst_in ? 2'h0 : {load_ov_flag_out, local_ov_flag_out};
		seen_q <= !srst_in && (seen_q || move);
		gap_q  <= (srst_in || move) ? 11'h001 : (gap_q == 11'h63F) ? 11'h000 : gap_q + 11'h001;
	end
	sequence s_take;
		psel_in && penable_in && !pready_out;
	endsequence
	sequence s_answer;
		##1 pready_out;
	endsequence
	ready_follows_a: assert property (s_take |-> s_answer) else $error("No ready after access.");
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("Ready held.");
	ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("Stray ready.");
	unmapped_err_a: assert property (s_take ##0 !hit |=> pslverr_out) else $error("No error.");
	mapped_ok_a: assert property (s_take ##0 hit |=> !pslverr_out) else $error("False error.");
	write_zero_a: assert property (s_take ##0 pwrite_in |=> prdata_out == 32'h0) else $error("Write data.");
	flag_grid_a:
		assert property (move && seen_q |-> gap_q == 11'h000) else $error("Flag off grid.");
	remote_on_a:
		assert property (!soft_start_in && oring_switch_enable_in |=> regulate_remote_out) else $error("Not remote.");
	remote_off_a:
		assert property (!regulate_remote_out && !rst_q |-> $past(soft_start_in || !oring_switch_enable_in))
			else $error("Wrongly local.");
endmodule : ovd_asserts

bind ovd_top ovd_asserts u_chk (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .soft_start_in(soft_start_in),
	.oring_switch_enable_in(oring_switch_enable_in), .pready_out(pready_out), .prdata_out(prdata_out),
	.pslverr_out(pslverr_out), .local_ov_flag_out(local_ov_flag_out), .load_ov_flag_out(load_ov_flag_out),
	.regulate_remote_out(regulate_remote_out));

/* ovd_consec.sv */
`timescale 1ns/10ps

module ovd_consec (
	input  wire logic                        clock_in,
	input  wire logic                        srst_in,
	input  wire logic                        done_in,
	input  wire logic                        exceed_in,
	input  wire logic [ovd_pkg::NEED_W-1:0]  need_in,
	output logic                             flag_out
);

	// ****************************************************************
	// Consecutive over-threshold period counter.
	// ****************************************************************
	logic [ovd_pkg::RUN_W-1:0] run_q;
	logic [ovd_pkg::RUN_W-1:0] run_d;
	logic [ovd_pkg::RUN_W-1:0] need_w;

	// Field 0..3 asks for one to four periods; the run saturates at four.
	assign need_w = {1'b0, need_in} + 3'h1;
	assign run_d  = (run_q == 3'h4) ? run_q : run_q + 3'h1;

	// Count only periods that exceed; any quiet period clears the run and the flag.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			run_q    <= '0;
			flag_out <= 1'b0;
		end else if (done_in) begin
			run_q    <= exceed_in ? run_d : '0;
			flag_out <= exceed_in && (run_d >= need_w);
		end
	end

endmodule : ovd_consec

/* ovd_period_avg.sv */
`timescale 1ns/10ps

module ovd_period_avg (
	input  wire logic                          clock_in,
	input  wire logic                          srst_in,
	input  wire logic                          period_end_in,
	input  wire logic [ovd_pkg::SAMPLE_W-1:0]  sample_in,
	input  wire logic [ovd_pkg::CODE_W-1:0]    code_in,
	output logic                               done_out,
	output logic                               exceed_out
);

	// ****************************************************************
	// Averaging over one period.
	// ****************************************************************
	logic [ovd_pkg::ACC_W-1:0] acc_q;
	logic [ovd_pkg::ACC_W-1:0] sum_w;
	logic [ovd_pkg::ACC_W-1:0] limit_w;

	// Sum including this cycle's sample; comparing the sum against threshold times
	// the period length equals comparing the average, without a divider.
	assign sum_w   = acc_q + ovd_pkg::ACC_W'(sample_in);
	assign limit_w = ovd_pkg::ACC_W'((ovd_pkg::THR_BASE + int'(code_in))
		* ovd_pkg::THR_SCALE * ovd_pkg::PERIOD_CYCLES);

	// Accumulator restarts at each period end and reports the verdict.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			acc_q      <= '0;
			done_out   <= 1'b0;
			exceed_out <= 1'b0;
		end else if (period_end_in) begin
			acc_q      <= '0;
			done_out   <= 1'b1;
			exceed_out <= (sum_w > limit_w);
		end else begin
			acc_q    <= sum_w;
			done_out <= 1'b0;
		end
	end

endmodule : ovd_period_avg

/* ovd_pkg.sv */
package ovd_pkg;

	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int CLK_PERIOD_NS    = 50;
	localparam int SAMPLE_PERIOD_NS = 80000;
	// Averaging period in clock cycles, rounded down and at least one.
	localparam int PERIOD_CYCLES_RAW = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PERIOD_CYCLES     = (PERIOD_CYCLES_RAW < 1) ? 1 : PERIOD_CYCLES_RAW;
	localparam int PERIOD_CNT_W      = 11;

	// ****************************************************************
	// Data widths and threshold arithmetic.
	// ****************************************************************
	localparam int SAMPLE_W  = 12;
	localparam int ACC_W     = 24;
	localparam int CODE_W    = 5;
	localparam int NEED_W    = 2;
	localparam int RUN_W     = 3;
	// Threshold is (base + code) / 128 of full scale; full scale is 2**SAMPLE_W counts.
	localparam int THR_BASE  = 89;
	localparam int THR_DENOM = 128;
	localparam int THR_SCALE = (1 << SAMPLE_W) / THR_DENOM;

	// ****************************************************************
	// Register indices; byte address is four times the index.
	// ****************************************************************
	localparam logic [7:0] IDX_LOCAL_OVL  = 8'h32;
	localparam logic [7:0] IDX_LOAD_OVL   = 8'h33;
	localparam logic [7:0] IDX_STATUS     = 8'h40;
	localparam logic [7:0] IDX_INT_EN     = 8'h41;
	localparam logic [7:0] IDX_INT_CLR    = 8'h42;
	localparam logic [7:0] IDX_FLAGS      = 8'h43;
	localparam int         ADDR_W         = 12;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int FLD_CODE_LSB  = 3;
	localparam int FLD_CODE_MSB  = 7;
	localparam int FLD_REGPT     = 2;
	localparam int FLD_NEED_LSB  = 0;
	localparam int FLD_NEED_MSB  = 1;
	localparam int EVT_LOCAL     = 0;
	localparam int EVT_LOAD      = 1;
	localparam int EVT_N         = 2;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [7:0]       RST_LOCAL_OVL = 8'h00;
	localparam logic [7:0]       RST_LOAD_OVL  = 8'h00;
	localparam logic [EVT_N-1:0] RST_INT_EN    = 2'h0;

endpackage : ovd_pkg

/* ovd_top.sv */
// Function
// - Flag when period average exceeds threshold
// - Sampling field picks one to four periods
// - Every consecutive period must exceed threshold
// - Load code bits 7:3 set threshold
// - Threshold is (89 + code)/128 of 1.55 V
// - Regulating bit set: always remote sense
// - Bit clear: local sense in soft start
// - Separate local register, same field layout
`timescale 1ns/10ps

module ovd_top (
	input  wire logic                          clock_in,
	input  wire logic                          srst_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [ovd_pkg::ADDR_W-1:0]    paddr_in,
	input  wire logic [31:0]                   pwdata_in,
	input  wire logic [3:0]                    pstrb_in,
	input  wire logic [ovd_pkg::SAMPLE_W-1:0]  local_sense_in,
	input  wire logic [ovd_pkg::SAMPLE_W-1:0]  load_sense_in,
	input  wire logic [ovd_pkg::SAMPLE_W-1:0]  remote_sense_in,
	input  wire logic                          soft_start_in,
	input  wire logic                          oring_switch_enable_in,
	output logic                               pready_out,
	output logic [31:0]                        prdata_out,
	output logic                               pslverr_out,
	output logic                               local_ov_flag_out,
	output logic                               load_ov_flag_out,
	output logic                               regulate_remote_out,
	output logic                               irq_out
);

	// ****************************************************************
	// Address decoding.
	// ****************************************************************

	// Registers sit one per aligned word, so the index is the byte address over four.
	// Any access with low address bits set is refused rather than rounded down.
	// True when the word address matches a register index.
	function automatic logic hits(input logic [ovd_pkg::ADDR_W-1:0] addr, input logic [7:0] idx);
		hits = (addr[1:0] == 2'h0) && (addr[ovd_pkg::ADDR_W-1:2] == {2'h0, idx});
	endfunction : hits

	logic hit_local_w;
	logic hit_load_w;
	logic hit_status_w;
	logic hit_en_w;
	logic hit_clr_w;
	logic hit_flags_w;
	logic hit_any_w;
	logic access_w;
	logic wr_w;
	logic wr_lane0_w;

	// Register selects; a misaligned address hits nothing.
	assign hit_local_w  = hits(paddr_in, ovd_pkg::IDX_LOCAL_OVL);
	assign hit_load_w   = hits(paddr_in, ovd_pkg::IDX_LOAD_OVL);
	assign hit_status_w = hits(paddr_in, ovd_pkg::IDX_STATUS);
	assign hit_en_w     = hits(paddr_in, ovd_pkg::IDX_INT_EN);
	assign hit_clr_w    = hits(paddr_in, ovd_pkg::IDX_INT_CLR);
	assign hit_flags_w  = hits(paddr_in, ovd_pkg::IDX_FLAGS);
	assign hit_any_w    = hit_local_w | hit_load_w | hit_status_w | hit_en_w | hit_clr_w | hit_flags_w;

	// Access phase is answered one cycle late; the write lands on the ready edge.
	assign access_w   = psel_in && penable_in;
	assign wr_w       = access_w && pready_out && pwrite_in && hit_any_w;
	assign wr_lane0_w = wr_w && pstrb_in[0];

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	logic [7:0]                local_ovl_q;
	logic [7:0]                load_ovl_q;
	logic [ovd_pkg::EVT_N-1:0] int_en_q;

	// Only lane zero carries register contents; upper lanes are ignored on write.
	// Bit 2 of the local limit is stored and read back but drives nothing.
	// A write with lane zero disabled leaves the registers untouched and is not an error.
	// Byte-wide registers written through lane zero.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			local_ovl_q <= ovd_pkg::RST_LOCAL_OVL;
			load_ovl_q  <= ovd_pkg::RST_LOAD_OVL;
			int_en_q    <= ovd_pkg::RST_INT_EN;
		end else if (wr_lane0_w) begin
			if (hit_local_w) begin
				local_ovl_q <= pwdata_in[7:0];
			end else if (hit_load_w) begin
				load_ovl_q <= pwdata_in[7:0];
			end else if (hit_en_w) begin
				int_en_q <= pwdata_in[ovd_pkg::EVT_N-1:0];
			end
		end
	end

	// Field extraction for both limit registers.
	logic [ovd_pkg::CODE_W-1:0] local_code_w;
	logic [ovd_pkg::CODE_W-1:0] load_code_w;
	logic [ovd_pkg::NEED_W-1:0] local_need_w;
	logic [ovd_pkg::NEED_W-1:0] load_need_w;
	logic                       regpt_w;

	assign load_code_w  = load_ovl_q[ovd_pkg::FLD_CODE_MSB:ovd_pkg::FLD_CODE_LSB];
	assign local_code_w = local_ovl_q[ovd_pkg::FLD_CODE_MSB:ovd_pkg::FLD_CODE_LSB];
	assign local_need_w = local_ovl_q[ovd_pkg::FLD_NEED_MSB:ovd_pkg::FLD_NEED_LSB];
	assign load_need_w  = load_ovl_q[ovd_pkg::FLD_NEED_MSB:ovd_pkg::FLD_NEED_LSB];
	assign regpt_w      = load_ovl_q[ovd_pkg::FLD_REGPT];

	// ****************************************************************
	// Period divider.
	// ****************************************************************
	logic [ovd_pkg::PERIOD_CNT_W-1:0] period_cnt_q;
	logic                             period_end_w;

	assign period_end_w = (period_cnt_q == ovd_pkg::PERIOD_CNT_W'(ovd_pkg::PERIOD_CYCLES - 1));

	// The divider never restarts on a configuration write, so all averagers and
	// software share one fixed period grid that starts at reset.
	// Free-running divider giving one enable pulse per averaging period.
	always_ff @(posedge clock_in) begin
		if (srst_in || period_end_w) begin
			period_cnt_q <= '0;
		end else begin
			period_cnt_q <= period_cnt_q + ovd_pkg::PERIOD_CNT_W'(1);
		end
	end

	// ****************************************************************
	// Averagers and consecutive-period counters.
	// ****************************************************************
	logic local_done_w;
	logic local_exc_w;
	logic load_done_w;
	logic load_exc_w;
	logic remote_exc_w;
	logic local_flag_w;
	logic load_flag_w;

	// Each averager reads its code at the period end, so a limit written in mid-period
	// applies to that whole period and never to part of one.
	// Software should therefore expect a new limit to act at the next period end.
	// local threshold comparison
	ovd_period_avg u_avg_local (
		.clock_in      (clock_in),
		.srst_in       (srst_in),
		.period_end_in (period_end_w),
		.sample_in     (local_sense_in),
		.code_in       (local_code_w),
		.done_out      (local_done_w),
		.exceed_out    (local_exc_w)
	);

	ovd_period_avg u_avg_load (
		.clock_in      (clock_in),
		.srst_in       (srst_in),
		.period_end_in (period_end_w),
		.sample_in     (load_sense_in),
		.code_in       (load_code_w),
		.done_out      (load_done_w),
		.exceed_out    (load_exc_w)
	);

	ovd_period_avg u_avg_remote (
		.clock_in      (clock_in),
		.srst_in       (srst_in),
		.period_end_in (period_end_w),
		.sample_in     (remote_sense_in),
		.code_in       (load_code_w),
		.done_out      (),
		.exceed_out    (remote_exc_w)
	);

	ovd_consec u_run_local (
		.clock_in  (clock_in),
		.srst_in   (srst_in),
		.done_in   (local_done_w),
		.exceed_in (local_exc_w),
		.need_in   (local_need_w),
		.flag_out  (local_flag_w)
	);

	// Load and remote nodes share one counter: a period counts when either node
	// averages above the shared limit, so one quiet node cannot mask the other.
	// A period in which neither node is above clears the run.
	// all periods must exceed
	ovd_consec u_run_load (
		.clock_in  (clock_in),
		.srst_in   (srst_in),
		.done_in   (load_done_w),
		.exceed_in (load_exc_w | remote_exc_w),
		.need_in   (load_need_w),
		.flag_out  (load_flag_w)
	);

	// ****************************************************************
	// Regulating point and flag outputs.
	// ****************************************************************
	logic regulate_remote_w;

	// With the regulating bit clear, feedback moves to the remote node only once soft
	// start is over and the oring switch conducts; both inputs are same-clock levels.
	// The choice is registered, so it follows its inputs by one cycle.
	// bit set forces remote
	assign regulate_remote_w = regpt_w || (!soft_start_in && oring_switch_enable_in);

	// Registered copies of the flags and the feedback selection.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			local_ov_flag_out   <= 1'b0;
			load_ov_flag_out    <= 1'b0;
			regulate_remote_out <= 1'b0;
		end else begin
			local_ov_flag_out   <= local_flag_w;
			load_ov_flag_out    <= load_flag_w;
			regulate_remote_out <= regulate_remote_w;
		end
	end

	// ****************************************************************
	// Interrupt status.
	// ****************************************************************
	logic [ovd_pkg::EVT_N-1:0] flag_now_w;
	logic [ovd_pkg::EVT_N-1:0] flag_prev_q;
	logic [ovd_pkg::EVT_N-1:0] status_q;
	logic [ovd_pkg::EVT_N-1:0] clr_w;

	// Rising edges of the flags are the events.
	assign flag_now_w = {load_flag_w, local_flag_w};
	assign clr_w      = (wr_lane0_w && hit_clr_w) ? pwdata_in[ovd_pkg::EVT_N-1:0] : '0;

	// Events are taken from the internal flags, one cycle ahead of the flag outputs.
	// Letting the set win means an event that meets a clear is never lost.
	// A flag that stays high raises no second event until it has fallen.
	// One sticky bit per event; a new event wins over a clear in the same cycle.
	genvar gi;
	generate
		for (gi = 0; gi < ovd_pkg::EVT_N; gi++) begin : g_sticky
			always_ff @(posedge clock_in) begin
				if (srst_in) begin
					flag_prev_q[gi] <= 1'b0;
					status_q[gi]    <= 1'b0;
				end else begin
					flag_prev_q[gi] <= flag_now_w[gi];
					if (flag_now_w[gi] && !flag_prev_q[gi]) begin
						status_q[gi] <= 1'b1;
					end else if (clr_w[gi]) begin
						status_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Enabling a bit that is already set raises the interrupt one cycle later, with no new event.
	// Level interrupt while any enabled status bit stands.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_q & int_en_q);
		end
	end

	// ****************************************************************
	// Bus answer.
	// ****************************************************************
	logic [31:0] rdata_w;

	// Unused upper bits read as zero so that wider software masks stay harmless.
	// Read mux; the clear register reads as zero.
	assign rdata_w = hit_local_w  ? {24'h000000, local_ovl_q} :
	                 hit_load_w   ? {24'h000000, load_ovl_q} :
	                 hit_status_w ? {30'h00000000, status_q} :
	                 hit_en_w     ? {30'h00000000, int_en_q} :
	                 hit_flags_w  ? {29'h00000000, regulate_remote_out, load_ov_flag_out, local_ov_flag_out} :
	                 32'h00000000;

	// Ready is raised only when it was low, so every access lasts exactly two cycles.
	// Read data stays until the next answer; writes return zero.
	// The error pulse marks an unmapped or misaligned address.
	// One wait state: ready rises in the second access cycle with data and error.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else if (access_w && !pready_out) begin
			pready_out  <= 1'b1;
			prdata_out  <= pwrite_in ? 32'h00000000 : rdata_w;
			pslverr_out <= !hit_any_w;
		end else begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

endmodule : ovd_top

/* tb.sv */
`timescale 1ns/10ps
module tb;
	// ****
	// Bench state.
	// ****
	localparam int PER = 80000 / 50;
	logic        clock_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0]  pstrb_in = 4'hF;
	logic [11:0] sen [3] = '{12'hFA0, 12'hFA0, 12'hFA0};
	logic        ss = 1'b0;
	logic        oe = 1'b1;
	logic        go = 1'b0;
	logic        pready, pslverr, lflag, aflag, regr, irq;
	logic [31:0] prdata, q;
	logic [7:0]  reg_m [2] = '{8'h00, 8'h00};
	logic [7:0]  wr_m [2] = '{8'h00, 8'h00};
	logic [7:0]  pnd [2] = '{8'h00, 8'h00};
	logic [1:0]  stat = 2'h0;
	logic [1:0]  en = 2'h0;
	logic [1:0]  mflag = 2'h0;
	int          fails = 0, checks_done = 0, ph = 0, n, j;
	int          run [2] = '{2, 2};
	int          tgt [3] = '{4000, 4000, 4000};
	int          sum [3] = '{0, 0, 0};

	ovd_top dut (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
		.local_sense_in(sen[0]), .load_sense_in(sen[1]), .remote_sense_in(sen[2]), .soft_start_in(ss),
		.oring_switch_enable_in(oe), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
		.local_ov_flag_out(lflag), .load_ov_flag_out(aflag), .regulate_remote_out(regr), .irq_out(irq));

	always #25 clock_in = ~clock_in;

	task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", w, x, g);
		end
	endtask : chk

	task automatic close_out();
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// One APB transfer; the request is held until ready is sampled high or 20 cycles pass.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int w;
		w = 0;
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clock_in);
			w++;
		end while (pready !== 1'b1 && w < 20);
		r = prdata;
		e = pslverr;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		chk("ready", 1, pready);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe, input string w);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(w, x, r);
		chk("slverr", xe, e);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk("write slverr", 0, e);
	endtask : wr

	function automatic int thr(input int c);
		return (89 + reg_m[c][7:3]) * (4096 / 128) * PER;
	endfunction : thr

	// Drives samples, sums them and updates the model at each period end.
	always @(posedge clock_in) begin
		if (go) begin
			if (ph == PER) begin
				for (int c = 0; c < 2; c++) begin
					run[c] = (c ? (sum[1] > thr(1) || sum[2] > thr(1)) : sum[0] > thr(0)) ? (run[c] < 4 ? run[c] + 1 : 4) : 0;
					if (run[c] > reg_m[c][1:0] && !mflag[c])
						stat[c] = 1'b1;
					mflag[c] = run[c] > reg_m[c][1:0];
					reg_m[c] = {pnd[c][7:2], (run[c] != 0) ? reg_m[c][1:0] : pnd[c][1:0]};
				end
				for (int k = 0; k < 3; k++) begin
					tgt[k] = (89 + reg_m[k > 0][7:3]) * 32 + ($urandom_range(3) ? 100 + $urandom_range(140) : -100 - int'($urandom_range(300)));
					sum[k] = 0;
				end
				ph = 0;
			end
			if (ph == 400) begin
				ss <= 1'($urandom_range(1));
				oe <= 1'($urandom_range(1));
			end
			if (ph == 403)
				chk("regulate", wr_m[1][2] | (!ss & oe), regr);
			if (ph == 800) begin
				chk("flags", mflag, {aflag, lflag});
				chk("irq", |(stat & en), irq);
			end
			for (int k = 0; k < 3; k++) begin
				j = $urandom_range(15);
				sen[k] <= 12'(tgt[k] + j);
				sum[k] += tgt[k] + j;
			end
			ph++;
		end
	end

	// Main sequence: reset values, refusals, then random periods.
	initial begin
		void'($urandom(32'hE57614BE));
		repeat (5) @(posedge clock_in);
		srst_in <= 1'b0;
		rd(12'h0C8, 0, 0, "local limit");
		rd(12'h0CC, 0, 0, "load limit");
		rd(12'h100, 0, 0, "status");
		rd(12'h104, 0, 0, "enable");
		rd(12'h200, 0, 1, "unmapped");
		rd(12'h0C9, 0, 1, "misaligned");
		pstrb_in <= 4'h0;
		wr(12'h0CC, 32'hFF);
		pstrb_in <= 4'hF;
		rd(12'h0CC, 0, 0, "strobe off");
		wr(12'h104, 32'h3);
		en = 2'h3;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (lflag !== 1'b1 && n < 2000);
		chk("first flag", 1, lflag);
		repeat (PER - 5) @(posedge clock_in);
		stat = 2'h3;
		mflag = 2'h3;
		go <= 1'b1;
		for (int s = 0; s < 40; s++) begin
			wait (ph == 1000);
			rd(12'h100, stat, 0, "status");
			rd(12'h10C, {wr_m[1][2] | (!ss & oe), mflag}, 0, "live flags");
			q = $urandom_range(3);
			wr(12'h108, q);
			stat &= ~q[1:0];
			en = 2'($urandom_range(3));
			wr(12'h104, en);
			for (int c = 0; c < 2; c++) begin
				wr(c ? 12'h0CC : 12'h0C8, reg_m[c]);
				wr_m[c] = reg_m[c];
				rd(c ? 12'h0CC : 12'h0C8, reg_m[c], 0, "limit");
				pnd[c] = 8'($urandom_range(255));
			end
		end
		close_out();
	end

	// Cuts a hang short.
	initial begin
		repeat (90000) @(posedge clock_in);
		fails++;
		close_out();
	end
endmodule : tb
